// >>> core/tbm_monitor.sv
// Temperature and battery monitor: registers, measurement and remote read
//
// Overview of operation
// - Any nonzero test selector makes the sensor oscillator run continuously.
// - Temperature high byte holds bits 10:3, next byte bits 7:5 hold 2:0.
// - With battery measure enabled, each temperature measurement includes battery.
// - Each battery reading is stored in the read-only battery result.
// - Battery-load bit, reset 0, applies the load in normal operating state.
// - In sleep the battery load is always disconnected.
// - Remote supply read requests both remote supply and remote temperature.
// - Interval 0 manual, 1 to 6 periodic 2^(3+code) s, 7 continuous.
// - Trigger starts one manual measurement, cleared at end, ignored asleep.
// - Supply select picks digital supply when 1; battery always in sleep.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "tbm_cfg.svh"
module tbm_monitor import tbm_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `TBM_SECOND_NS / `TBM_CLOCK_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire tbm_addr_t reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_state,
  input wire logic normal_operating_state,
  output logic sense_start,
  output logic sense_batt_en,
  output logic sense_osc_continuous,
  input wire logic sense_done,
  input wire logic [10:0] sense_temp,
  input wire logic [7:0] sense_batt,
  output logic sensor_from_digital,
  output logic battery_load_on,
  output logic remote_req,
  output logic remote_sel,
  input wire logic remote_valid,
  input wire logic [10:0] remote_data
);
  logic [1:0] test_sel;
  logic load_en;
  logic [2:0] interval;
  logic batt_meas_en;
  logic supply_sel;
  logic trigger;
  logic [10:0] temp_result;
  logic [7:0] battery_result;
  logic [7:0] remote_supply_result;
  logic [10:0] remote_temp_result;
  tbm_meas_e mstate;
  tbm_rem_e rstate;
  logic go;
  logic meas_done;
  logic [7:0] next_rdata;

  // Scheduler decides when a new measurement may start
  tbm_sched #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_sched (
    .clock(clock),
    .rst(rst),
    .interval(interval),
    .trigger(trigger),
    .sleep_state(sleep_state),
    .go(go)
  );

  assign meas_done = (mstate == TBM_M_RUN) && sense_done;

  // Control register writes
  always_ff @(posedge clock) begin
    if (rst) begin
      test_sel <= `TBM_TEST_RST;
      load_en <= `TBM_LOAD_RST;
      interval <= `TBM_INTERVAL_RST;
      batt_meas_en <= 1'b0;
      supply_sel <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `TBM_ADDR_TEST) begin
        test_sel <= reg_wdata[1:0];
      end else if (reg_addr == `TBM_ADDR_LOAD) begin
        load_en <= reg_wdata[`TBM_LOAD_BIT];
      end else if (reg_addr == `TBM_ADDR_CFG) begin
        interval <= reg_wdata[2:0];
        batt_meas_en <= reg_wdata[`TBM_CFG_BATT_BIT];
        supply_sel <= reg_wdata[`TBM_CFG_SUPPLY_BIT];
      end
    end
  end

  // Manual trigger: software write wins, hardware clears on completion
  always_ff @(posedge clock) begin
    if (rst) begin
      trigger <= 1'b0;
    end else if (reg_wr && reg_addr == `TBM_ADDR_START && !sleep_state) begin
      trigger <= reg_wdata[`TBM_START_BIT] &&
                 (interval == `TBM_INTERVAL_MANUAL);
    end else if (meas_done) begin
      trigger <= 1'b0;
    end
  end

  // Measurement sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      mstate <= TBM_M_IDLE;
      sense_start <= 1'b0;
      sense_batt_en <= 1'b0;
    end else begin
      sense_start <= 1'b0;
      case (mstate)
        TBM_M_IDLE: begin
          if (go) begin
            mstate <= TBM_M_RUN;
            sense_start <= 1'b1;
            sense_batt_en <= batt_meas_en;
          end
        end
        TBM_M_RUN: begin
          if (sense_done) begin
            mstate <= TBM_M_IDLE;
          end
        end
        default: begin
          mstate <= TBM_M_IDLE;
        end
      endcase
    end
  end

  // Results captured only at measurement end; battery result only when battery was measured
  always_ff @(posedge clock) begin
    if (rst) begin
      temp_result <= `TBM_RESULT11_RST;
      battery_result <= `TBM_RESULT8_RST;
    end else if (meas_done) begin
      temp_result <= sense_temp;
      if (sense_batt_en) begin
        battery_result <= sense_batt;
      end
    end
  end

  // Sensor oscillator, supply and battery load controls
  always_ff @(posedge clock) begin
    if (rst) begin
      sense_osc_continuous <= 1'b0;
      sensor_from_digital <= 1'b0;
      battery_load_on <= 1'b0;
    end else begin
      sense_osc_continuous <= (test_sel != 2'h0);
      sensor_from_digital <= supply_sel && !sleep_state;
      battery_load_on <= load_en && normal_operating_state &&
                         !sleep_state;
    end
  end

  // Remote sensor read: supply first, then temperature
  always_ff @(posedge clock) begin
    if (rst) begin
      rstate <= TBM_R_IDLE;
      remote_supply_result <= `TBM_RESULT8_RST;
      remote_temp_result <= `TBM_RESULT11_RST;
    end else begin
      case (rstate)
        TBM_R_IDLE: begin
          if (reg_wr && reg_addr == `TBM_ADDR_REM_CTRL &&
              reg_wdata[`TBM_REM_GO_BIT]) begin
            rstate <= TBM_R_SUP;
          end
        end
        TBM_R_SUP: begin
          rstate <= TBM_R_SUP_W;
        end
        TBM_R_SUP_W: begin
          if (remote_valid) begin
            remote_supply_result <= remote_data[7:0];
            rstate <= TBM_R_TMP;
          end
        end
        TBM_R_TMP: begin
          rstate <= TBM_R_TMP_W;
        end
        TBM_R_TMP_W: begin
          if (remote_valid) begin
            remote_temp_result <= remote_data;
            rstate <= TBM_R_IDLE;
          end
        end
        default: begin
          rstate <= TBM_R_IDLE;
        end
      endcase
    end
  end

  // Request strobes for the remote link
  always_comb begin
    remote_req = (rstate == TBM_R_SUP) || (rstate == TBM_R_TMP);
    remote_sel = (rstate == TBM_R_TMP);
  end

  // Read decode; result registers have no write path
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == `TBM_ADDR_TEST) begin
      next_rdata = {6'h00, test_sel};
    end else if (reg_addr == `TBM_ADDR_LOAD) begin
      next_rdata[`TBM_LOAD_BIT] = load_en;
    end else if (reg_addr == `TBM_ADDR_TEMP_HI) begin
      next_rdata = temp_result[10:3];
    end else if (reg_addr == `TBM_ADDR_TEMP_LO) begin
      next_rdata = {temp_result[2:0], 5'h00};
    end else if (reg_addr == `TBM_ADDR_BATT) begin
      next_rdata = battery_result;
    end else if (reg_addr == `TBM_ADDR_CFG) begin
      next_rdata[2:0] = interval;
      next_rdata[`TBM_CFG_BATT_BIT] = batt_meas_en;
      next_rdata[`TBM_CFG_SUPPLY_BIT] = supply_sel;
    end else if (reg_addr == `TBM_ADDR_START) begin
      next_rdata[`TBM_START_BIT] = trigger;
    end else if (reg_addr == `TBM_ADDR_REM_CTRL) begin
      next_rdata[`TBM_REM_BUSY_BIT] = (rstate != TBM_R_IDLE);
      next_rdata[`TBM_MEAS_BUSY_BIT] = (mstate == TBM_M_RUN);
    end else if (reg_addr == `TBM_ADDR_REM_SUP) begin
      next_rdata = remote_supply_result;
    end else if (reg_addr == `TBM_ADDR_REM_THI) begin
      next_rdata = remote_temp_result[10:3];
    end else if (reg_addr == `TBM_ADDR_REM_TLO) begin
      next_rdata = {remote_temp_result[2:0], 5'h00};
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence sup_answered;
    rstate == TBM_R_SUP_W && remote_valid;
  endsequence

  sequence tmp_requested;
    remote_req && remote_sel;
  endsequence

  osc_continuous_a: assert property (
    test_sel != 2'h0 |=> sense_osc_continuous)
    else $error("oscillator not continuous under test code");

  temp_split_a: assert property (
    reg_rd && reg_addr == `TBM_ADDR_TEMP_LO
    |=> reg_rdata == {$past(temp_result[2:0]), 5'h00})
    else $error("temperature low byte misplaced");

  batt_flag_a: assert property (
    sense_start |-> sense_batt_en == $past(batt_meas_en))
    else $error("battery measure flag not taken at start");

  batt_store_a: assert property (
    meas_done && sense_batt_en |=> battery_result == $past(sense_batt))
    else $error("battery reading not stored");

  load_sleep_a: assert property (
    sleep_state |=> !battery_load_on)
    else $error("battery load applied in sleep");

  load_apply_a: assert property (
    load_en && normal_operating_state && !sleep_state
    |=> battery_load_on)
    else $error("battery load not applied");

  remote_both_a: assert property (
    sup_answered |=> tmp_requested)
    else $error("remote temperature not requested after supply");

  trig_clear_a: assert property (
    meas_done && !(reg_wr && reg_addr == `TBM_ADDR_START)
    |=> !trigger)
    else $error("trigger not cleared at completion");

  supply_sleep_a: assert property (
    sleep_state |=> !sensor_from_digital)
    else $error("digital supply used in sleep");

  result_hold_a: assert property (
    !meas_done |=> $stable(temp_result) && $stable(battery_result))
    else $error("result changed outside measurement end");

  cont_start_a: assert property (
    interval == `TBM_INTERVAL_CONT && mstate == TBM_M_IDLE
    |=> sense_start && mstate == TBM_M_RUN)
    else $error("continuous mode did not start a measurement");
endmodule

// >>> core/tbm_cfg.svh
// Offsets, field positions, reset values and timing for the monitor
`ifndef TBM_CFG_SVH
`define TBM_CFG_SVH

// Register byte addresses
`define TBM_ADDR_TEST 16'h2500
`define TBM_ADDR_LOAD 16'h2704
`define TBM_ADDR_TEMP_HI 16'h2881
`define TBM_ADDR_TEMP_LO 16'h2882
`define TBM_ADDR_BATT 16'h2885
`define TBM_ADDR_CFG 16'h28A0
`define TBM_ADDR_START 16'h28B4
`define TBM_ADDR_REM_CTRL 16'h2890
`define TBM_ADDR_REM_SUP 16'h2891
`define TBM_ADDR_REM_THI 16'h2892
`define TBM_ADDR_REM_TLO 16'h2893

// Field positions
`define TBM_LOAD_BIT 3
`define TBM_CFG_SUPPLY_BIT 6
`define TBM_CFG_BATT_BIT 4
`define TBM_START_BIT 6
`define TBM_REM_GO_BIT 0
`define TBM_REM_BUSY_BIT 0
`define TBM_MEAS_BUSY_BIT 1

// Reset values
`define TBM_TEST_RST 2'h0
`define TBM_LOAD_RST 1'h0
`define TBM_INTERVAL_RST 3'h0
`define TBM_RESULT8_RST 8'h00
`define TBM_RESULT11_RST 11'h000

// Interval codes
`define TBM_INTERVAL_MANUAL 3'h0
`define TBM_INTERVAL_CONT 3'h7
`define TBM_PERIOD_BASE 4'h3

// Timing
`define TBM_CLOCK_NS 10
`define TBM_SECOND_NS 1000000000

`endif

// >>> core/tbm_pkg.sv
// Types shared by the temperature and battery monitor
package tbm_pkg;
  typedef enum logic [0:0] {
    TBM_M_IDLE,
    TBM_M_RUN
  } tbm_meas_e;

  typedef enum logic [2:0] {
    TBM_R_IDLE,
    TBM_R_SUP,
    TBM_R_SUP_W,
    TBM_R_TMP,
    TBM_R_TMP_W
  } tbm_rem_e;

  typedef logic [15:0] tbm_addr_t;
endpackage

// >>> core/tbm_sched.sv
// Measurement scheduler: manual, periodic and continuous start requests
`timescale 1ns/1ps
`include "tbm_cfg.svh"
module tbm_sched import tbm_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `TBM_SECOND_NS / `TBM_CLOCK_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] interval,
  input wire logic trigger,
  input wire logic sleep_state,
  output logic go
);
  logic [31:0] sec_cnt;
  logic [9:0] secs;
  logic tick_go;
  logic [10:0] period;
  logic periodic;

  // Period in seconds is two to the power of three plus the code
  always_comb begin
    period = 11'd1 << (`TBM_PERIOD_BASE + {1'b0, interval});
    periodic = (interval != `TBM_INTERVAL_MANUAL) &&
               (interval != `TBM_INTERVAL_CONT);
  end

  // Second prescaler and seconds counter, idle outside periodic codes
  always_ff @(posedge clock) begin
    if (rst || !periodic) begin
      sec_cnt <= 32'h0;
      secs <= 10'h000;
      tick_go <= 1'b0;
    end else if (sec_cnt == 32'(SEC_CYCLES - 1)) begin
      sec_cnt <= 32'h0;
      if (secs == 10'(period - 11'd1)) begin
        secs <= 10'h000;
        tick_go <= 1'b1;
      end else begin
        secs <= secs + 10'h001;
        tick_go <= 1'b0;
      end
    end else begin
      sec_cnt <= sec_cnt + 32'h1;
      tick_go <= 1'b0;
    end
  end

  // Start request; manual trigger is ignored while asleep
  always_comb begin
    go = tick_go ||
         (interval == `TBM_INTERVAL_CONT) ||
         ((interval == `TBM_INTERVAL_MANUAL) && trigger &&
          !sleep_state);
  end
endmodule

// >>> verification/tbm_monitor_tb.sv
// Self-checking bench for the temperature and battery monitor
`timescale 1ns/1ps
`include "tbm_cfg.svh"
module tbm_monitor_tb import tbm_pkg::*;;
  localparam int SEC = 4;
  logic clock = 0;
  logic rst = 1;
  tbm_addr_t reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, sense_batt = '0;
  logic reg_wr = 0, reg_rd = 0, sleep_state = 0, normal_operating_state = 1;
  logic sense_start, sense_batt_en, sense_osc_continuous, sense_done = 0;
  logic [10:0] sense_temp = '0, remote_data = '0;
  logic sensor_from_digital, battery_load_on, remote_req, remote_sel;
  logic remote_valid = 0;
  int n_fail = 0, compares = 0, cyc = 0;
  time t0;

  tbm_monitor #(.SEC_CYCLES(SEC)) i_tbm_monitor (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_state(sleep_state),
    .normal_operating_state(normal_operating_state),
    .sense_start(sense_start), .sense_batt_en(sense_batt_en),
    .sense_osc_continuous(sense_osc_continuous), .sense_done(sense_done),
    .sense_temp(sense_temp), .sense_batt(sense_batt),
    .sensor_from_digital(sensor_from_digital),
    .battery_load_on(battery_load_on), .remote_req(remote_req),
    .remote_sel(remote_sel), .remote_valid(remote_valid),
    .remote_data(remote_data));

  // Free-running 100 MHz clock
  initial begin
    forever #5 clock = ~clock;
  end

  // Cuts a hung run short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [10:0] exp, logic [10:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One-cycle bus write
  task automatic wr(tbm_addr_t a, logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clock);
    reg_wr <= 0;
  endtask

  // One-cycle bus read, data checked in the following cycle
  task automatic rd(tbm_addr_t a, logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clock);
    reg_rd <= 0;
    #1 chk($sformatf("read %h", a), exp, reg_rdata);
  endtask

  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic setst(logic s, logic n);
    @(posedge clock);
    sleep_state <= s;
    normal_operating_state <= n;
    settle;
  endtask

  // Waits a bounded time for a conversion start
  task automatic wait_start;
    int k;
    #1;
    for (k = 0; k < 300 && sense_start !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk("sense_start", 1, sense_start);
  endtask

  // Sensor answer; data is only valid beside the done pulse
  task automatic done(logic [10:0] t, logic [7:0] b);
    @(posedge clock);
    sense_done <= 1;
    sense_temp <= t;
    sense_batt <= b;
    @(posedge clock);
    sense_done <= 0;
    sense_temp <= ~t;
    sense_batt <= ~b;
  endtask

  task automatic wait_req(logic sel);
    int k;
    #1;
    for (k = 0; k < 20 && remote_req !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    chk("remote_req", 1, remote_req);
    chk("remote_sel", 11'(sel), 11'(remote_sel));
  endtask

  task automatic reply(logic [10:0] d);
    @(posedge clock);
    remote_valid <= 1;
    remote_data <= d;
    @(posedge clock);
    remote_valid <= 0;
    remote_data <= ~d;
  endtask

  initial begin
    logic seen;
    repeat (4) @(posedge clock);
    rst <= 0;
    // Reset values and an unmapped address
    rd(`TBM_ADDR_TEST, 8'h00);
    rd(`TBM_ADDR_LOAD, 8'h00);
    rd(`TBM_ADDR_TEMP_HI, 8'h00);
    rd(`TBM_ADDR_BATT, 8'h00);
    rd(16'h2000, 8'h00);
    $display("Test reset done");
    // Every selector code, ending at the normal code
    for (int c = 3; c >= 0; c--) begin
      wr(`TBM_ADDR_TEST, 8'(c));
      settle;
      chk("osc", 11'(c != 0), 11'(sense_osc_continuous));
      rd(`TBM_ADDR_TEST, 8'(c));
    end
    $display("Test selector done");
    // Supply select, load and chip states
    wr(`TBM_ADDR_CFG, 8'hD0);
    rd(`TBM_ADDR_CFG, 8'h50);
    wr(`TBM_ADDR_LOAD, 8'h08);
    settle;
    chk("load", 1, battery_load_on);
    chk("supply", 1, sensor_from_digital);
    rd(`TBM_ADDR_LOAD, 8'h08);
    setst(1, 1);
    chk("load sleep", 0, battery_load_on);
    chk("supply sleep", 0, sensor_from_digital);
    setst(0, 0);
    chk("load not normal", 0, battery_load_on);
    setst(0, 1);
    chk("load back", 1, battery_load_on);
    $display("Test load done");
    // Manual measurement with battery
    wr(`TBM_ADDR_START, 8'h40);
    wait_start;
    chk("batt_en", 1, sense_batt_en);
    done(11'h5A3, 8'hC7);
    rd(`TBM_ADDR_TEMP_HI, 8'hB4);
    rd(`TBM_ADDR_TEMP_LO, 8'h60);
    rd(`TBM_ADDR_BATT, 8'hC7);
    rd(`TBM_ADDR_START, 8'h00);
    wr(`TBM_ADDR_TEMP_HI, 8'hFF);
    wr(`TBM_ADDR_BATT, 8'h00);
    rd(`TBM_ADDR_TEMP_HI, 8'hB4);
    rd(`TBM_ADDR_BATT, 8'hC7);
    // Manual measurement without battery keeps the old reading
    wr(`TBM_ADDR_CFG, 8'h40);
    wr(`TBM_ADDR_START, 8'h40);
    wait_start;
    chk("batt_en off", 0, sense_batt_en);
    done(11'h123, 8'h11);
    rd(`TBM_ADDR_TEMP_HI, 8'h24);
    rd(`TBM_ADDR_BATT, 8'hC7);
    // Second battery reading with the load removed, for impedance
    wr(`TBM_ADDR_LOAD, 8'h00);
    wr(`TBM_ADDR_CFG, 8'h50);
    wr(`TBM_ADDR_START, 8'h40);
    wait_start;
    rd(`TBM_ADDR_REM_CTRL, 8'h02);
    done(11'h123, 8'hC9);
    rd(`TBM_ADDR_BATT, 8'hC9);
    chk("load off", 0, battery_load_on);
    $display("Test manual done");
    // Periodic interval code 1
    wr(`TBM_ADDR_CFG, 8'h01);
    wait_start;
    t0 = $time;
    done(11'h001, 8'h01);
    wait_start;
    chk("period", 11'(16 * SEC), 11'(($time - t0) / 10));
    wr(`TBM_ADDR_CFG, 8'h07);
    done(11'h002, 8'h02);
    // Continuous interval code 7
    wait_start;
    done(11'h003, 8'h03);
    t0 = $time;
    wait_start;
    chk("continuous", 1, 11'(($time - t0) <= 40));
    wr(`TBM_ADDR_CFG, 8'h00);
    done(11'h004, 8'h04);
    $display("Test schedule done");
    // Trigger ignored in sleep
    setst(1, 1);
    wr(`TBM_ADDR_START, 8'h40);
    seen = 0;
    repeat (20) begin
      @(posedge clock);
      #1 seen = seen | (sense_start !== 1'b0);
    end
    chk("sleep start", 0, 11'(seen));
    rd(`TBM_ADDR_START, 8'h00);
    setst(0, 1);
    $display("Test sleep done");
    // Remote supply read asks for supply then temperature
    wr(`TBM_ADDR_REM_CTRL, 8'h01);
    wait_req(0);
    rd(`TBM_ADDR_REM_CTRL, 8'h01);
    reply(11'h0A5);
    wait_req(1);
    reply(11'h6B2);
    rd(`TBM_ADDR_REM_SUP, 8'hA5);
    rd(`TBM_ADDR_REM_THI, 8'hD6);
    rd(`TBM_ADDR_REM_TLO, 8'h40);
    rd(`TBM_ADDR_REM_CTRL, 8'h00);
    $display("Test remote done");
    // Mid-run reset returns controls and results to reset values
    wr(`TBM_ADDR_LOAD, 8'h08);
    @(posedge clock);
    rst <= 1;
    repeat (2) @(posedge clock);
    rst <= 0;
    settle;
    chk("load reset", 0, battery_load_on);
    rd(`TBM_ADDR_LOAD, 8'h00);
    rd(`TBM_ADDR_BATT, 8'h00);
    rd(`TBM_ADDR_REM_SUP, 8'h00);
    $display("Test reset again done");
    wrap_up;
  end
endmodule
